// file: hw/bcis_pkg.sv
// Constants, field layouts and carrier types for the instruction sequencer.
// Assumes a single 100 MHz clock domain shared by RAM, message engine and host port.
package bcis_pkg;

	// ****************************************
	// Register addresses
	// ****************************************
	localparam logic [7:0] BCIS_ADDR_MCFG = 8'h00;
	localparam logic [7:0] BCIS_ADDR_IRQ_EN = 8'h10;
	localparam logic [7:0] BCIS_ADDR_START = 8'h33;
	localparam logic [7:0] BCIS_ADDR_PTR = 8'h34;
	localparam logic [7:0] BCIS_ADDR_COND = 8'h37;

	localparam int BCIS_MCFG_ENA_BIT = 12;
	localparam int BCIS_MCFG_START_BIT = 13;
	localparam int BCIS_IRQ_TRAP_BIT = 4;

	// ****************************************
	// Op code word layout
	// ****************************************
	localparam int BCIS_PAR_BIT = 15;
	localparam int BCIS_OPC_HI = 14;
	localparam int BCIS_OPC_LO = 10;
	localparam int BCIS_VAL_HI = 9;
	localparam int BCIS_VAL_LO = 5;
	localparam int BCIS_INV_BIT = 4;
	localparam int BCIS_CSEL_HI = 3;
	localparam logic [4:0] BCIS_VALID_PATTERN = 5'h0a;

	// Op code encodings
	localparam logic [4:0] BCIS_OPC_HALT = 5'h00;
	localparam logic [4:0] BCIS_OPC_MSG = 5'h01;
	localparam logic [4:0] BCIS_OPC_NOP = 5'h02;
	localparam logic [4:0] BCIS_OPC_FLG = 5'h0a;
	localparam logic [4:0] BCIS_OPC_CMT = 5'h0b;
	localparam logic [4:0] BCIS_OPC_CFT = 5'h0c;
	localparam logic [31:0] BCIS_OPC_DEFINED = 32'h0000_1c07;

	localparam logic [15:0] BCIS_ENTRY_WORDS = 16'h0002;
	localparam logic [15:0] BCIS_PARAM_OFFSET = 16'h0001;

	// ****************************************
	// Message control word fields
	// ****************************************
	localparam int BCIS_CTL_RETRY_HI = 1;
	localparam int BCIS_CTL_RETRY_LO = 0;
	localparam int BCIS_CTL_SWITCH_BIT = 2;
	localparam int BCIS_CTL_BUS_BIT = 3;
	localparam logic [1:0] BCIS_MAX_RETRIES = 2'h2;

	// ****************************************
	// Carriers
	// ****************************************
	typedef struct packed {
		logic rd;
		logic [15:0] addr;
	} bcis_ram_req_t;

	typedef struct packed {
		logic go;
		logic bus_b;
		logic [15:0] block_addr;
	} bcis_msg_req_t;

	typedef struct packed {
		logic resp_timeout;
		logic manchester;
		logic sync_type;
		logic bit_count;
		logic word_parity;
		logic word_count;
		logic rt_addr;
	} bcis_msg_err_t;

	typedef struct packed {
		logic done;
		logic [7:0] outcome;
	} bcis_msg_result_t;

endpackage : bcis_pkg

// file: hw/bcis_opword_check.sv
// Legality check of a fetched op code word.
// Assumes the word is stable while the sequencer sits in its execute state.
`timescale 1ns/1ps
module bcis_opword_check (
	input wire logic [15:0] word_in,   // Fetched op code word
	output logic parity_err_out,       // Even parity seen
	output logic valid_err_out,        // Validation field wrong
	output logic opcode_err_out,       // Op code not defined
	output logic illegal_out           // Any of the above
);
	import bcis_pkg::*;

	always_comb begin
		parity_err_out = ~(^word_in);
		valid_err_out = word_in[BCIS_VAL_HI:BCIS_VAL_LO] != BCIS_VALID_PATTERN;
		opcode_err_out = ~BCIS_OPC_DEFINED[word_in[BCIS_OPC_HI:BCIS_OPC_LO]];
		illegal_out = parity_err_out | valid_err_out | opcode_err_out;
	end

endmodule : bcis_opword_check

// file: hw/bcis_msg_retry.sv
// Message launch with per-message retry and optional bus switch.
// Assumes the bus engine answers every go with exactly one done pulse.
`timescale 1ns/1ps
module bcis_msg_retry (
	input wire logic clk_sys_in,                     // System clock
	input wire logic rst_in,                         // Sync reset, high
	input wire logic start_in,                       // Launch pulse
	input wire logic [15:0] ctl_in,                  // Message control word
	input wire logic [15:0] block_addr_in,           // Control block address
	output bcis_pkg::bcis_msg_req_t msg_req_out,     // Request to bus engine
	input wire logic msg_done_in,                    // Engine finished attempt
	input wire bcis_pkg::bcis_msg_err_t msg_err_in,  // Engine error checks
	output bcis_pkg::bcis_msg_result_t result_out    // Final outcome pulse
);
	import bcis_pkg::*;

	logic busy;
	logic [1:0] retries_left;
	logic [1:0] retries_done;
	logic switch_bus;
	logic switched;
	logic any_err;
	logic format_err;

	// Every check of the engine counts as a failed attempt
	assign any_err = |msg_err_in;
	assign format_err = msg_err_in.manchester | msg_err_in.sync_type | msg_err_in.bit_count
		| msg_err_in.word_parity | msg_err_in.word_count | msg_err_in.rt_addr;

	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			busy <= 1'b0;
			retries_left <= 2'h0;
			retries_done <= 2'h0;
			switch_bus <= 1'b0;
			switched <= 1'b0;
			msg_req_out <= '0;
			result_out <= '0;
		end else begin
			msg_req_out.go <= 1'b0;
			result_out.done <= 1'b0;
			if (start_in && !busy) begin
				busy <= 1'b1;
				// Counts above two are clipped rather than refused
				retries_left <= (ctl_in[BCIS_CTL_RETRY_HI:BCIS_CTL_RETRY_LO] > BCIS_MAX_RETRIES)
					? BCIS_MAX_RETRIES : ctl_in[BCIS_CTL_RETRY_HI:BCIS_CTL_RETRY_LO];
				retries_done <= 2'h0;
				switch_bus <= ctl_in[BCIS_CTL_SWITCH_BIT];
				switched <= 1'b0;
				msg_req_out.go <= 1'b1;
				msg_req_out.bus_b <= ctl_in[BCIS_CTL_BUS_BIT];
				msg_req_out.block_addr <= block_addr_in;
			end else if (busy && msg_done_in) begin
				if (any_err && retries_left != 2'h0) begin
					retries_left <= retries_left - 2'h1;
					retries_done <= retries_done + 2'h1;
					msg_req_out.go <= 1'b1;
					if (switch_bus) begin
						msg_req_out.bus_b <= ~msg_req_out.bus_b;
						switched <= 1'b1;
					end
				end else begin
					busy <= 1'b0;
					result_out.done <= 1'b1;
					result_out.outcome <= {any_err, msg_err_in.resp_timeout, format_err,
						retries_done != 2'h0, retries_done == BCIS_MAX_RETRIES, switched,
						msg_req_out.bus_b, ~any_err};
				end
			end
		end
	end

endmodule : bcis_msg_retry

// file: hw/bcis_sequencer.sv
// Bus controller instruction list sequencer with condition codes and host registers.
// Assumes RAM, message engine, timers and host register strobes share clk_sys_in.
// Behaviour
// - Pointer is loaded from the start address register before execution.
// - Sequencer advances the pointer itself and fetches op codes from it.
// - Each list entry is two words: op code, then parameter.
// - Op word: parity 15, op code 14-10, validation 9-5, condition 4-0.
// - Halt at once on an op word with even parity.
// - Halt at once on an undefined op code.
// - Halt at once when validation field is not 01010.
// - Illegal op word raises trap interrupt when its enable bit is set.
// - Condition bits 3-0 select a code; bit 4 gives the inverse of the required outcome.
// - Host reads all sixteen condition codes at address 0x0037.
// - Codes 1000-1111 follow the outcome of the last finished message.
// - Flag op code can toggle, set or clear each general flag.
// - Host write to 0x0037 toggles, sets or clears the general flags.
// - Timer compare op codes change only flags 0 and 1.
// - Timer compare sets flag 0 when parameter is below the timer.
// - Code 0 is less-than or flag 0; inverse is greater-or-equal.
// - Messages may retry once or twice, optionally on the other bus.
// - Every message is checked for all bus protocol errors.
`timescale 1ns/1ps
module bcis_sequencer (
	input wire logic clk_sys_in,                       // System clock
	input wire logic rst_in,                           // Sync reset, high
	input wire logic [7:0] reg_addr_in,                // Register address
	input wire logic reg_wr_in,                        // Register write strobe
	input wire logic [15:0] reg_wdata_in,              // Register write data
	input wire logic reg_rd_in,                        // Register read strobe
	output logic [15:0] reg_rdata_out,                 // Register read data
	output bcis_pkg::bcis_ram_req_t ram_req_out,       // RAM read request
	input wire logic ram_ack_in,                       // RAM data valid
	input wire logic [15:0] ram_rdata_in,              // RAM read data
	output bcis_pkg::bcis_msg_req_t msg_req_out,       // Message launch
	input wire logic msg_done_in,                      // Message attempt done
	input wire bcis_pkg::bcis_msg_err_t msg_err_in,    // Message error checks
	input wire logic [15:0] time_to_next_msg_in,       // Message timer value
	input wire logic [15:0] frame_time_remaining_in,   // Frame timer value
	output logic running_out,                          // Executing the list
	output logic illegal_opcode_trap_out               // Trap interrupt pulse
);
	import bcis_pkg::*;

	// ****************************************
	// Declarations
	// ****************************************
	typedef enum logic [3:0] {
		S_IDLE, S_OP_RD, S_OP_WT, S_PAR_RD, S_PAR_WT, S_EXEC, S_CTL_RD, S_CTL_WT, S_MSG
	} bcis_state_t;

	bcis_state_t state;
	logic controller_enable;
	logic [15:0] irq_enable;
	logic [15:0] start_addr;
	logic [15:0] list_ptr;
	logic [15:0] op_word;
	logic [15:0] param_word;
	logic [15:0] ram_addr;
	logic [7:0] general_flags;
	logic [7:0] outcome_codes;
	logic [15:0] cond_codes;
	logic illegal;
	logic cond_met;
	logic start_evt;
	logic enable_now;
	logic host_flag_wr;
	logic exec_go;
	logic [4:0] opcode;
	logic [15:0] timer_sel;
	logic msg_start;
	bcis_msg_result_t msg_result;
	logic [7:0] next_flags;

	// ****************************************
	// Submodules
	// ****************************************
	bcis_opword_check u_check (
		.word_in(op_word),
		.parity_err_out(),
		.valid_err_out(),
		.opcode_err_out(),
		.illegal_out(illegal)
	);

	bcis_msg_retry u_retry (
		.clk_sys_in(clk_sys_in),
		.rst_in(rst_in),
		.start_in(msg_start),
		.ctl_in(ram_rdata_in),
		.block_addr_in(param_word),
		.msg_req_out(msg_req_out),
		.msg_done_in(msg_done_in),
		.msg_err_in(msg_err_in),
		.result_out(msg_result)
	);

	// ****************************************
	// Decode helpers
	// ****************************************
	assign opcode = op_word[BCIS_OPC_HI:BCIS_OPC_LO];
	assign cond_codes = {outcome_codes, general_flags};
	// Selected code must equal the inverse of bit 4 to run
	assign cond_met = cond_codes[op_word[BCIS_CSEL_HI:0]] ^ op_word[BCIS_INV_BIT];
	assign exec_go = (state == S_EXEC) && !illegal && cond_met;
	assign start_evt = reg_wr_in && reg_addr_in == BCIS_ADDR_MCFG
		&& reg_wdata_in[BCIS_MCFG_START_BIT] && reg_wdata_in[BCIS_MCFG_ENA_BIT];
	// Written enable acts in the same cycle, so start and halt need no extra edge
	assign enable_now = (reg_wr_in && reg_addr_in == BCIS_ADDR_MCFG)
		? reg_wdata_in[BCIS_MCFG_ENA_BIT] : controller_enable;
	assign host_flag_wr = reg_wr_in && reg_addr_in == BCIS_ADDR_COND;
	assign timer_sel = (opcode == BCIS_OPC_CMT) ? time_to_next_msg_in : frame_time_remaining_in;
	assign msg_start = (state == S_CTL_WT) && ram_ack_in;
	assign ram_req_out.rd = (state == S_OP_RD) || (state == S_PAR_RD) || (state == S_CTL_RD);
	assign ram_req_out.addr = ram_addr;
	assign running_out = state != S_IDLE;

	// Low byte sets, high byte clears, both together toggle
	function automatic logic [7:0] apply_mask(input logic [7:0] cur, input logic [15:0] m);
		logic [7:0] set_m;
		logic [7:0] clr_m;
		set_m = m[7:0];
		clr_m = m[15:8];
		apply_mask = ((cur | set_m) & ~clr_m) | ((set_m & clr_m) & ~cur);
	endfunction : apply_mask

	// ****************************************
	// Host registers
	// ****************************************
	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			controller_enable <= 1'b0;
			irq_enable <= 16'h0000;
			start_addr <= 16'h0000;
		end else if (reg_wr_in) begin
			unique case (reg_addr_in)
				BCIS_ADDR_MCFG: controller_enable <= reg_wdata_in[BCIS_MCFG_ENA_BIT];
				BCIS_ADDR_IRQ_EN: irq_enable <= reg_wdata_in;
				BCIS_ADDR_START: start_addr <= reg_wdata_in;
				default: ;
			endcase
		end
	end

	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			reg_rdata_out <= 16'h0000;
		end else if (reg_rd_in) begin
			unique case (reg_addr_in)
				BCIS_ADDR_MCFG: begin
					reg_rdata_out <= 16'h0000;
					reg_rdata_out[BCIS_MCFG_ENA_BIT] <= controller_enable;
					reg_rdata_out[BCIS_MCFG_START_BIT] <= running_out;
				end
				BCIS_ADDR_IRQ_EN: reg_rdata_out <= irq_enable;
				BCIS_ADDR_START: reg_rdata_out <= start_addr;
				BCIS_ADDR_PTR: reg_rdata_out <= list_ptr;
				BCIS_ADDR_COND: reg_rdata_out <= cond_codes;
				default: reg_rdata_out <= 16'h0000;
			endcase
		end
	end

	// ****************************************
	// Sequencer
	// ****************************************
	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			state <= S_IDLE;
			list_ptr <= 16'h0000;
			ram_addr <= 16'h0000;
			op_word <= 16'h0000;
			param_word <= 16'h0000;
		end else if (!enable_now) begin
			// Dropping enable abandons the list at once
			state <= S_IDLE;
		end else begin
			unique case (state)
				S_IDLE: begin
					if (start_evt) begin
						list_ptr <= start_addr;
						ram_addr <= start_addr;
						state <= S_OP_RD;
					end
				end
				S_OP_RD: state <= S_OP_WT;
				S_OP_WT: begin
					if (ram_ack_in) begin
						op_word <= ram_rdata_in;
						ram_addr <= list_ptr + BCIS_PARAM_OFFSET;
						state <= S_PAR_RD;
					end
				end
				S_PAR_RD: state <= S_PAR_WT;
				S_PAR_WT: begin
					if (ram_ack_in) begin
						param_word <= ram_rdata_in;
						state <= S_EXEC;
					end
				end
				S_EXEC: begin
					if (illegal) begin
						state <= S_IDLE;
					end else if (!cond_met || opcode != BCIS_OPC_MSG) begin
						if (cond_met && opcode == BCIS_OPC_HALT) begin
							state <= S_IDLE;
						end else begin
							list_ptr <= list_ptr + BCIS_ENTRY_WORDS;
							ram_addr <= list_ptr + BCIS_ENTRY_WORDS;
							state <= S_OP_RD;
						end
					end else begin
						// Control word sits first in the message block
						ram_addr <= param_word;
						state <= S_CTL_RD;
					end
				end
				S_CTL_RD: state <= S_CTL_WT;
				S_CTL_WT: begin
					if (ram_ack_in) begin
						state <= S_MSG;
					end
				end
				S_MSG: begin
					if (msg_result.done) begin
						list_ptr <= list_ptr + BCIS_ENTRY_WORDS;
						ram_addr <= list_ptr + BCIS_ENTRY_WORDS;
						state <= S_OP_RD;
					end
				end
			endcase
		end
	end

	// ****************************************
	// Trap
	// ****************************************
	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			illegal_opcode_trap_out <= 1'b0;
		end else begin
			illegal_opcode_trap_out <= enable_now && state == S_EXEC && illegal
				&& irq_enable[BCIS_IRQ_TRAP_BIT];
		end
	end

	// ****************************************
	// Condition codes
	// ****************************************
	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			outcome_codes <= 8'h00;
		end else if (msg_result.done) begin
			outcome_codes <= msg_result.outcome;
		end
	end

	// Host write lands after the op code, so host wins a same-cycle clash
	always_comb begin
		next_flags = general_flags;
		if (exec_go) begin
			unique case (opcode)
				BCIS_OPC_FLG: next_flags = apply_mask(general_flags, param_word);
				BCIS_OPC_CMT, BCIS_OPC_CFT: begin
					next_flags[0] = param_word < timer_sel;
					next_flags[1] = param_word == timer_sel;
				end
				default: ;
			endcase
		end
		if (host_flag_wr) begin
			next_flags = apply_mask(next_flags, reg_wdata_in);
		end
	end

	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			general_flags <= 8'h00;
		end else begin
			general_flags <= next_flags;
		end
	end

endmodule : bcis_sequencer

// file: tb/bcis_seq_properties.sv
// Concurrent checks on the sequencer top ports.
// Assumes binding onto bcis_sequencer; one clock, sync reset high.
`timescale 1ns/1ps
module bcis_seq_properties (
	input wire logic clk_sys_in, // Clock
	input wire logic rst_in, // Sync reset
	input wire logic [7:0] reg_addr_in, // Register address
	input wire logic reg_wr_in, // Write strobe
	input wire logic [15:0] reg_wdata_in, // Write data
	input wire logic reg_rd_in, // Read strobe
	input wire logic [15:0] reg_rdata_out, // Read data
	input wire bcis_pkg::bcis_ram_req_t ram_req_out, // Fetch request
	input wire logic ram_ack_in, // Fetch answer
	input wire bcis_pkg::bcis_msg_req_t msg_req_out, // Message launch
	input wire logic running_out, // Executing
	input wire logic illegal_opcode_trap_out // Trap pulse
);
	import bcis_pkg::*;
	logic [15:0] start_q;
	logic wait_q;
	logic mapped;
	default clocking cb @(posedge clk_sys_in); endclocking
	default disable iff (rst_in);
	assign mapped = reg_addr_in inside {BCIS_ADDR_MCFG, BCIS_ADDR_IRQ_EN, BCIS_ADDR_START,
		BCIS_ADDR_PTR, BCIS_ADDR_COND};
	always_ff @(posedge clk_sys_in) begin
		if (rst_in) start_q <= 16'h0000;
		else if (reg_wr_in && reg_addr_in == BCIS_ADDR_START) start_q <= reg_wdata_in;
	end
	// Cleared when idle so a halt mid-fetch leaves no stale wait
	always_ff @(posedge clk_sys_in) begin
		if (rst_in || !running_out) wait_q <= 1'b0;
		else if (ram_req_out.rd) wait_q <= 1'b1;
		else if (ram_ack_in) wait_q <= 1'b0;
	end
	// ****************************************
	// Assertions
	// ****************************************
	a_start_loads_ptr: assert property (reg_wr_in && reg_addr_in == BCIS_ADDR_MCFG &&
		reg_wdata_in[13:12] == 2'h3 && !running_out
		|=> running_out && ram_req_out.rd && ram_req_out.addr == start_q)
		else $error("first fetch not at start address");
	a_fetch_addr_stable: assert property (wait_q && !ram_req_out.rd |-> $stable(ram_req_out.addr))
		else $error("fetch address moved while waiting");
	a_fetch_one_cycle: assert property (ram_req_out.rd |-> running_out ##1 !ram_req_out.rd)
		else $error("fetch request not a single idle-free pulse");
	a_enable_off_halts: assert property (reg_wr_in && reg_addr_in == BCIS_ADDR_MCFG &&
		!reg_wdata_in[12] |=> !running_out)
		else $error("clearing enable did not halt");
	a_trap_stops_run: assert property ($rose(illegal_opcode_trap_out) |-> !running_out
		##1 !illegal_opcode_trap_out) else $error("trap without stop or not a pulse");
	a_unmapped_reads_zero: assert property (reg_rd_in && !mapped |=> reg_rdata_out == 16'h0000)
		else $error("unmapped read not zero");
	a_go_single_pulse: assert property (msg_req_out.go |-> running_out ##1 !msg_req_out.go)
		else $error("message launch not a single pulse");
	a_rdata_holds: assert property (!reg_rd_in |=> $stable(reg_rdata_out))
		else $error("read data changed without a read");
	c_start: cover property (running_out && ram_req_out.rd);
	c_trap: cover property (illegal_opcode_trap_out);
	c_retry: cover property (msg_req_out.go ##[1:20] msg_req_out.go);
endmodule : bcis_seq_properties

// file: tb/bcis_far_model.sv
// Behavioural RAM and bus message engine beside the sequencer.
// Assumes the bench preloads mem and sets speed and failure count.
`timescale 1ns/1ps
module bcis_far_model (
	input wire logic clk_sys_in, // Clock
	input wire logic rst_in, // Sync reset
	input wire bcis_pkg::bcis_ram_req_t ram_req_in, // Fetch request
	input wire bcis_pkg::bcis_msg_req_t msg_req_in, // Message launch
	input wire logic slow_in, // Slow RAM answers
	input wire logic [3:0] fail_in, // Attempts that fail
	output logic ram_ack_out, // Data valid
	output logic [15:0] ram_rdata_out, // Fetch data
	output logic msg_done_out, // Attempt done
	output bcis_pkg::bcis_msg_err_t msg_err_out // Error flags
);
	import bcis_pkg::*;
	logic [15:0] mem [0:1023];
	logic [15:0] a_q;
	logic [1:0] cnt;
	logic [2:0] mcnt;
	logic [3:0] n_go;
	logic bus_log [0:7];
	// Words served one per request, in the order asked
	always_ff @(posedge clk_sys_in) begin
		ram_ack_out <= 1'b0;
		ram_rdata_out <= ~ram_rdata_out; // Released data never repeats the last word
		if (rst_in) begin
			cnt <= 2'h0;
			ram_rdata_out <= 16'h5a5a;
		end else if (ram_req_in.rd) begin
			a_q <= ram_req_in.addr;
			cnt <= slow_in ? 2'h3 : 2'h1;
		end else if (cnt != 2'h0) begin
			cnt <= cnt - 2'h1;
			if (cnt == 2'h1) begin
				ram_ack_out <= 1'b1;
				ram_rdata_out <= mem[a_q[9:0]];
			end
		end
	end
	// Error flags are junk outside the done pulse
	always_ff @(posedge clk_sys_in) begin
		msg_done_out <= 1'b0;
		msg_err_out <= '1;
		if (rst_in) begin
			mcnt <= 3'h0;
			n_go <= 4'h0;
		end else if (msg_req_in.go) begin
			mcnt <= 3'h4;
			bus_log[n_go[2:0]] <= msg_req_in.bus_b;
			n_go <= n_go + 4'h1;
		end else if (mcnt != 3'h0) begin
			mcnt <= mcnt - 3'h1;
			if (mcnt == 3'h1) begin
				msg_done_out <= 1'b1;
				msg_err_out <= {(n_go <= fail_in), 6'h00};
			end
		end
	end
endmodule : bcis_far_model

// file: tb/test_bcis_sequencer.sv
// Self-checking bench for the instruction sequencer.
// Assumes bcis_far_model as RAM and message engine.
`timescale 1ns/1ps
module test_bcis_sequencer;
	import bcis_pkg::*;
	logic clk_sys_in = 1'b0;
	logic rst_in = 1'b1;
	logic [7:0] reg_addr_in = 8'h00;
	logic reg_wr_in = 1'b0;
	logic [15:0] reg_wdata_in = 16'h0000;
	logic reg_rd_in = 1'b0;
	logic [15:0] reg_rdata_out;
	bcis_ram_req_t ram_req_out;
	logic ram_ack_in;
	logic [15:0] ram_rdata_in;
	bcis_msg_req_t msg_req_out;
	logic msg_done_in;
	bcis_msg_err_t msg_err_in;
	logic running_out;
	logic illegal_opcode_trap_out;
	logic slow = 1'b0;
	int n_mismatch = 0;
	int n_checks = 0;
	int n_trap = 0;
	int t0;
	logic [15:0] bad [0:2];
	bcis_sequencer u_bcis_sequencer (.clk_sys_in(clk_sys_in), .rst_in(rst_in),
		.reg_addr_in(reg_addr_in), .reg_wr_in(reg_wr_in), .reg_wdata_in(reg_wdata_in),
		.reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out), .ram_req_out(ram_req_out),
		.ram_ack_in(ram_ack_in), .ram_rdata_in(ram_rdata_in), .msg_req_out(msg_req_out),
		.msg_done_in(msg_done_in), .msg_err_in(msg_err_in), .time_to_next_msg_in(16'h0010),
		.frame_time_remaining_in(16'h0003), .running_out(running_out),
		.illegal_opcode_trap_out(illegal_opcode_trap_out));
	bcis_far_model u_bcis_far_model (.clk_sys_in(clk_sys_in), .rst_in(rst_in),
		.ram_req_in(ram_req_out), .msg_req_in(msg_req_out), .slow_in(slow), .fail_in(4'h1),
		.ram_ack_out(ram_ack_in), .ram_rdata_out(ram_rdata_in), .msg_done_out(msg_done_in),
		.msg_err_out(msg_err_in));
	initial begin
		forever #5 clk_sys_in = ~clk_sys_in;
	end
	always @(posedge clk_sys_in) if (illegal_opcode_trap_out === 1'b1) n_trap++;
	// ****************************************
	// Tasks
	// ****************************************
	function automatic logic [15:0] mk(input logic [4:0] opc, input logic inv, input logic [3:0] sel);
		logic [14:0] w;
		w = {opc, BCIS_VALID_PATTERN, inv, sel};
		return {~^w, w};
	endfunction : mk
	task automatic close_out();
		if (n_mismatch == 0 && n_checks > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask : close_out
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("Error t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge clk_sys_in) #1;
		reg_addr_in = a;
		reg_wdata_in = d;
		reg_wr_in = 1'b1;
		@(posedge clk_sys_in) #1;
		reg_wr_in = 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [15:0] exp);
		@(posedge clk_sys_in) #1;
		reg_addr_in = a;
		reg_rd_in = 1'b1;
		@(posedge clk_sys_in) #1;
		reg_rd_in = 1'b0;
		chk(reg_rdata_out, exp);
	endtask : rd
	task automatic run(input logic [15:0] start);
		int i;
		wr(BCIS_ADDR_START, start);
		wr(BCIS_ADDR_MCFG, 16'h3000);
		for (i = 0; i < 300 && running_out !== 1'b0; i++) @(posedge clk_sys_in) #1;
		if (running_out !== 1'b0) begin
			n_mismatch++;
			close_out();
		end
	endtask : run
	// ****************************************
	// Sequence
	// ****************************************
	initial begin
		repeat (10) @(posedge clk_sys_in);
		#1 rst_in = 1'b0;
		rd(BCIS_ADDR_MCFG, 16'h0000);
		rd(BCIS_ADDR_PTR, 16'h0000);
		rd(8'h20, 16'h0000);
		wr(BCIS_ADDR_MCFG, 16'h2000);
		chk({15'h0, running_out}, 16'h0000);
		// Skip on unmet condition, compares touch flags 0 and 1 only
		u_bcis_far_model.mem[16'h100] = mk(BCIS_OPC_CMT, 1'b1, 4'h0);
		u_bcis_far_model.mem[16'h101] = 16'h0005;
		u_bcis_far_model.mem[16'h102] = mk(BCIS_OPC_HALT, 1'b1, 4'h0);
		u_bcis_far_model.mem[16'h104] = mk(BCIS_OPC_CFT, 1'b0, 4'h0);
		u_bcis_far_model.mem[16'h105] = 16'h0003;
		u_bcis_far_model.mem[16'h106] = mk(BCIS_OPC_HALT, 1'b0, 4'h1);
		wr(BCIS_ADDR_COND, 16'h0080);
		wr(BCIS_ADDR_PTR, 16'h0777);
		run(16'h0100);
		rd(BCIS_ADDR_COND, 16'h0082);
		rd(BCIS_ADDR_PTR, 16'h0106);
		wr(BCIS_ADDR_COND, 16'h0381);
		rd(BCIS_ADDR_COND, 16'h0081);
		// Illegal words: parity, validation, undefined op code
		bad[0] = mk(BCIS_OPC_NOP, 1'b1, 4'h0) ^ 16'h8000;
		bad[1] = mk(BCIS_OPC_NOP, 1'b1, 4'h0) ^ 16'h0060;
		bad[2] = mk(5'h1f, 1'b1, 4'h0);
		wr(BCIS_ADDR_IRQ_EN, 16'h0010);
		for (int k = 0; k < 4; k++) begin
			if (k == 3) wr(BCIS_ADDR_IRQ_EN, 16'h0000);
			u_bcis_far_model.mem[16'h200] = bad[k % 3];
			t0 = n_trap;
			run(16'h0200);
			rd(BCIS_ADDR_PTR, 16'h0200);
			chk(16'(n_trap - t0), (k == 3) ? 16'h0000 : 16'h0001);
		end
		// Message retried once on the other bus, slow RAM, then flag op and no-op
		slow = 1'b1;
		u_bcis_far_model.mem[16'h300] = mk(BCIS_OPC_MSG, 1'b1, 4'h2);
		u_bcis_far_model.mem[16'h301] = 16'h0380;
		u_bcis_far_model.mem[16'h302] = mk(BCIS_OPC_FLG, 1'b1, 4'h2);
		u_bcis_far_model.mem[16'h303] = 16'h0104;
		u_bcis_far_model.mem[16'h304] = mk(BCIS_OPC_NOP, 1'b1, 4'h3);
		u_bcis_far_model.mem[16'h306] = mk(BCIS_OPC_HALT, 1'b1, 4'h0);
		u_bcis_far_model.mem[16'h380] = 16'h0005;
		run(16'h0300);
		chk({12'h0, u_bcis_far_model.n_go}, 16'h0002);
		chk({15'h0, u_bcis_far_model.bus_log[1]}, 16'h0001);
		chk(msg_req_out.block_addr, 16'h0380);
		rd(BCIS_ADDR_COND, 16'h1784);
		rd(BCIS_ADDR_PTR, 16'h0306);
		close_out();
	end
endmodule : test_bcis_sequencer
bind bcis_sequencer bcis_seq_properties u_bcis_seq_properties (.clk_sys_in(clk_sys_in),
	.rst_in(rst_in), .reg_addr_in(reg_addr_in), .reg_wr_in(reg_wr_in),
	.reg_wdata_in(reg_wdata_in), .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out),
	.ram_req_out(ram_req_out), .ram_ack_in(ram_ack_in), .msg_req_out(msg_req_out),
	.running_out(running_out), .illegal_opcode_trap_out(illegal_opcode_trap_out));
